/* hdl/cbe_branch_eval.sv */
`timescale 1ns/10ps
// Function
// - Carry-set jump loads PC plus offset plus one when carry is 1.
// - Carry-clear jump is taken only when carry is 0.
// - Unsigned not-below jump equals carry-clear: taken when carry is 0.
// - Unsigned below jump equals carry-set: taken when carry is 1.
// - Negative jump taken when negative flag is 1, else falls through.
// - Nonnegative jump taken when negative flag is 0, else falls through.
// - Signed not-less jump taken when negative xor overflow is 0.
// - Signed less jump taken when negative xor overflow is 1.
// - Half-carry-set jump taken when half-carry flag is 1.
// - Half-carry-clear jump taken when half-carry flag is 0.
// - Transfer-bit jump taken when transfer flag is 1.
// - No status flag changes; each branch takes one or two cycles.
module cbe_branch_eval (
  input  wire logic                      ref_clk,
  input  wire logic                      rst_b,
  input  wire logic                      br_valid,
  input  wire cbe_pkg::cbe_cond_t        br_cond,
  input  wire logic [cbe_pkg::OFS_W-1:0] br_offset,
  input  wire logic [cbe_pkg::PC_W-1:0]  pc_in,
  input  wire logic                      flag_carry,
  input  wire logic                      flag_negative,
  input  wire logic                      flag_overflow,
  input  wire logic                      flag_halfcarry,
  input  wire logic                      flag_transfer,
  output logic                           pc_load,
  output logic [cbe_pkg::PC_W-1:0]       pc_target,
  output logic                           flush,
  output logic                           busy,
  output logic                           done,
  output logic                           taken
);
  import cbe_pkg::*;

  // ==========================================================================
  // State
  typedef struct packed {
    cbe_state_t      st;
    logic            pc_load;
    logic [PC_W-1:0] pc_target;
    logic            flush;
    logic            busy;
    logic            done;
    logic            taken;
  } cbe_regs_t;

  // Every pulse clears; the jump address starts from the PC reset value
  localparam cbe_regs_t REGS_RESET = '{
    st:        CBE_ST_IDLE,
    pc_load:   1'h0,
    pc_target: PC_RESET,
    flush:     1'h0,
    busy:      1'h0,
    done:      1'h0,
    taken:     1'h0
  };

  cbe_regs_t       r_reg;
  cbe_regs_t       r_next;
  logic            req_accept;
  logic            cond_hit;
  logic [PC_W-1:0] jump_addr;

  // ==========================================================================
  // Condition tests, one function per flag family
  function automatic logic cbe_carry_test(input cbe_cond_t c,
                                          input logic      cf);
    logic res;
    res = 1'h0;
    unique case (c)
      CBE_JUMP_WHEN_CARRY_SET: begin
        res = cf;
      end
      CBE_JUMP_WHEN_CARRY_CLEAR: begin
        res = !cf;
      end
      CBE_JUMP_UNSIGNED_NOT_BELOW: begin
        res = !cf;
      end
      CBE_JUMP_UNSIGNED_BELOW: begin
        res = cf;
      end
      default: begin
        res = 1'h0;
      end
    endcase
    return res;
  endfunction

  function automatic logic cbe_sign_test(input cbe_cond_t c,
                                         input logic      nf);
    logic res;
    res = 1'h0;
    unique case (c)
      CBE_JUMP_WHEN_NEGATIVE: begin
        res = nf;
      end
      CBE_JUMP_WHEN_NONNEGATIVE: begin
        res = !nf;
      end
      default: begin
        res = 1'h0;
      end
    endcase
    return res;
  endfunction

  function automatic logic cbe_signed_test(input cbe_cond_t c,
                                           input logic      nf,
                                           input logic      vf);
    logic res;
    res = 1'h0;
    unique case (c)
      CBE_JUMP_SIGNED_NOT_LESS: begin
        res = !(nf ^ vf);
      end
      CBE_JUMP_SIGNED_LESS: begin
        res = nf ^ vf;
      end
      default: begin
        res = 1'h0;
      end
    endcase
    return res;
  endfunction

  function automatic logic cbe_half_test(input cbe_cond_t c,
                                         input logic      hf);
    logic res;
    res = 1'h0;
    unique case (c)
      CBE_JUMP_WHEN_HALFCARRY_SET: begin
        res = hf;
      end
      CBE_JUMP_WHEN_HALFCARRY_CLEAR: begin
        res = !hf;
      end
      default: begin
        res = 1'h0;
      end
    endcase
    return res;
  endfunction

  function automatic logic cbe_transfer_test(input cbe_cond_t c,
                                             input logic      tf);
    logic res;
    res = 1'h0;
    unique case (c)
      CBE_JUMP_WHEN_TRANSFER_BIT_SET: begin
        res = tf;
      end
      default: begin
        res = 1'h0;
      end
    endcase
    return res;
  endfunction

  // Codes above the transfer-bit jump are spares and must never branch
  function automatic logic cbe_code_known(input cbe_cond_t c);
    logic res;
    res = 1'h0;
    unique case (c)
      CBE_JUMP_WHEN_CARRY_SET,
      CBE_JUMP_WHEN_CARRY_CLEAR,
      CBE_JUMP_UNSIGNED_NOT_BELOW,
      CBE_JUMP_UNSIGNED_BELOW,
      CBE_JUMP_WHEN_NEGATIVE,
      CBE_JUMP_WHEN_NONNEGATIVE,
      CBE_JUMP_SIGNED_NOT_LESS,
      CBE_JUMP_SIGNED_LESS,
      CBE_JUMP_WHEN_HALFCARRY_SET,
      CBE_JUMP_WHEN_HALFCARRY_CLEAR,
      CBE_JUMP_WHEN_TRANSFER_BIT_SET: begin
        res = 1'h1;
      end
      default: begin
        res = 1'h0;
      end
    endcase
    return res;
  endfunction

  function automatic logic cbe_cond_true(input cbe_cond_t c,
                                         input logic      cf,
                                         input logic      nf,
                                         input logic      vf,
                                         input logic      hf,
                                         input logic      tf);
    logic hit_any;
    hit_any = cbe_carry_test(c, cf) |
              cbe_sign_test(c, nf) |
              cbe_signed_test(c, nf, vf) |
              cbe_half_test(c, hf) |
              cbe_transfer_test(c, tf);
    return hit_any && cbe_code_known(c);
  endfunction

  // ==========================================================================
  // Jump address arithmetic
  // Offset is a signed word displacement, sign-extended to PC width
  function automatic logic [PC_W-1:0] cbe_sext(input logic [OFS_W-1:0] ofs);
    logic [PC_W-1:0] ext;
    ext = {{(PC_W-OFS_W){ofs[OFS_W-1]}}, ofs};
    return ext;
  endfunction

  // Wraps modulo the PC width, just as the program counter itself does
  function automatic logic [PC_W-1:0] cbe_target(input logic [PC_W-1:0]  pc,
                                                  input logic [OFS_W-1:0] ofs);
    logic [PC_W-1:0] sum;
    sum = pc + cbe_sext(ofs) + PC_ONE;
    return sum;
  endfunction

  // ==========================================================================
  // Per-state next values
  function automatic cbe_regs_t cbe_idle_next(input cbe_regs_t       cur,
                                              input logic            accept,
                                              input logic            hit,
                                              input logic [PC_W-1:0] addr);
    cbe_regs_t nxt;
    nxt         = cur;
    nxt.pc_load = 1'h0;
    nxt.flush   = 1'h0;
    nxt.busy    = 1'h0;
    nxt.done    = 1'h0;
    nxt.taken   = 1'h0;
    if (accept && hit) begin
      // Taken: redirect and discard the fetched word now, second cycle raises done
      nxt.pc_load   = 1'h1;
      nxt.pc_target = addr;
      nxt.flush     = 1'h1;
      nxt.busy      = 1'h1;
      nxt.taken     = 1'h1;
      nxt.st        = CBE_ST_FLUSH;
    end else if (accept) begin
      // Fall through finishes in a single cycle
      nxt.done = 1'h1;
    end
    return nxt;
  endfunction

  function automatic cbe_regs_t cbe_flush_next(input cbe_regs_t cur);
    cbe_regs_t nxt;
    nxt         = cur;
    nxt.pc_load = 1'h0;
    nxt.flush   = 1'h0;
    nxt.taken   = 1'h0;
    // The flush state blocks a new request so a taken branch holds exactly two cycles
    nxt.busy    = 1'h0;
    nxt.done    = 1'h1;
    nxt.st      = CBE_ST_IDLE;
    return nxt;
  endfunction

  // Illegal state codes fall back to idle but keep the last jump address
  function automatic cbe_regs_t cbe_recover_next(input cbe_regs_t cur);
    cbe_regs_t nxt;
    nxt           = REGS_RESET;
    nxt.pc_target = cur.pc_target;
    return nxt;
  endfunction

  // ==========================================================================
  // Request decode
  assign req_accept = br_valid && (r_reg.st == CBE_ST_IDLE);
  assign cond_hit   = cbe_cond_true(br_cond, flag_carry, flag_negative, flag_overflow,
                                    flag_halfcarry, flag_transfer);
  assign jump_addr  = cbe_target(pc_in, br_offset);

  // ==========================================================================
  // Next state
  always_comb begin
    r_next = r_reg;
    unique case (r_reg.st)
      CBE_ST_IDLE: begin
        r_next = cbe_idle_next(r_reg, req_accept, cond_hit, jump_addr);
      end
      CBE_ST_FLUSH: begin
        r_next = cbe_flush_next(r_reg);
      end
      default: begin
        r_next = cbe_recover_next(r_reg);
      end
    endcase
  end

  // ==========================================================================
  // Registers; no flag outputs exist, so status flags are never altered
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      r_reg <= REGS_RESET;
    end else begin
      r_reg <= r_next;
    end
  end

  // ==========================================================================
  // Outputs
  assign pc_load   = r_reg.pc_load;
  assign pc_target = r_reg.pc_target;
  assign flush     = r_reg.flush;
  assign busy      = r_reg.busy;
  assign done      = r_reg.done;
  assign taken     = r_reg.taken;
endmodule

/* hdl/cbe_pkg.sv */
package cbe_pkg;
  // ==========================================================================
  // Widths
  localparam int PC_W  = 16;
  localparam int OFS_W = 7;

  // ==========================================================================
  // Reset values and constants
  localparam logic [PC_W-1:0] PC_RESET = 16'h0000;
  localparam logic [PC_W-1:0] PC_ONE   = 16'h0001;

  // ==========================================================================
  // Condition selector codes
  typedef enum logic [3:0] {
    CBE_JUMP_WHEN_CARRY_SET          = 4'h0,
    CBE_JUMP_WHEN_CARRY_CLEAR        = 4'h1,
    CBE_JUMP_UNSIGNED_NOT_BELOW      = 4'h2,
    CBE_JUMP_UNSIGNED_BELOW          = 4'h3,
    CBE_JUMP_WHEN_NEGATIVE           = 4'h4,
    CBE_JUMP_WHEN_NONNEGATIVE        = 4'h5,
    CBE_JUMP_SIGNED_NOT_LESS         = 4'h6,
    CBE_JUMP_SIGNED_LESS             = 4'h7,
    CBE_JUMP_WHEN_HALFCARRY_SET      = 4'h8,
    CBE_JUMP_WHEN_HALFCARRY_CLEAR    = 4'h9,
    CBE_JUMP_WHEN_TRANSFER_BIT_SET   = 4'hA
  } cbe_cond_t;

  // ==========================================================================
  // Sequencer states, one-hot
  typedef enum logic [1:0] {
    CBE_ST_IDLE  = 2'h1,
    CBE_ST_FLUSH = 2'h2
  } cbe_state_t;
endpackage

/* verification/cbe_branch_eval_assertions.sv */
`timescale 1ns/10ps
module cbe_chk (
  input logic                      ref_clk,
  input logic                      rst_b,
  input logic                      br_valid,
  input cbe_pkg::cbe_cond_t        br_cond,
  input logic [cbe_pkg::OFS_W-1:0] br_offset,
  input logic [cbe_pkg::PC_W-1:0]  pc_in,
  input logic                      flag_carry,
  input logic                      flag_negative,
  input logic                      flag_overflow,
  input logic                      flag_halfcarry,
  input logic                      flag_transfer,
  input logic                      pc_load,
  input logic [cbe_pkg::PC_W-1:0]  pc_target,
  input logic                      flush,
  input logic                      busy,
  input logic                      done,
  input logic                      taken
);
  // ====================
  // Acceptance and jump address
  logic        go;
  logic [15:0] tgt;
  assign go = br_valid && !busy;
  assign tgt = pc_in + {{9{br_offset[6]}}, br_offset} + 16'h0001;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  a_carry_set: assert property (go && br_cond inside {0, 3}
    |=> taken == $past(flag_carry)) else $error("carry");
  a_carry_clear: assert property (go && br_cond inside {1, 2}
    |=> taken != $past(flag_carry)) else $error("clear");
  a_sign_jump: assert property (go && br_cond[3:1] == 2
    |=> taken == ($past(flag_negative) ^ $past(br_cond[0]))) else $error("sign");
  a_signed_cmp: assert property (go && br_cond[3:1] == 3
    |=> taken != ($past(flag_negative) ^ $past(flag_overflow) ^ $past(br_cond[0]))) else $error("signed");
  a_half_jump: assert property (go && br_cond[3:1] == 4
    |=> taken == ($past(flag_halfcarry) ^ $past(br_cond[0]))) else $error("half");
  a_transfer_jump: assert property (go && br_cond == 4'hA
    |=> taken == $past(flag_transfer)) else $error("transfer");
  a_jump_target: assert property (go ##1 taken
    |-> pc_target == $past(tgt)) else $error("target");
  a_taken_shape: assert property (taken
    |-> pc_load && flush && busy ##1 done && !busy && !taken) else $error("shape");
  a_request_answer: assert property (go
    |=> taken != done) else $error("answer");
  a_spare_code: assert property (go && br_cond > 4'hA
    |=> done && !taken) else $error("spare");
  a_busy_refuse: assert property (busy && br_valid
    |=> !taken && !pc_load) else $error("refuse");
  cover property (go ##1 taken);
  cover property (go ##1 done);
  cover property (go && br_offset[6] ##1 taken);
  cover property (busy && br_valid);
endmodule
bind cbe_branch_eval cbe_chk u_chk (
  .ref_clk        (ref_clk),
  .rst_b          (rst_b),
  .br_valid       (br_valid),
  .br_cond        (br_cond),
  .br_offset      (br_offset),
  .pc_in          (pc_in),
  .flag_carry     (flag_carry),
  .flag_negative  (flag_negative),
  .flag_overflow  (flag_overflow),
  .flag_halfcarry (flag_halfcarry),
  .flag_transfer  (flag_transfer),
  .pc_load        (pc_load),
  .pc_target      (pc_target),
  .flush          (flush),
  .busy           (busy),
  .done           (done),
  .taken          (taken)
);

/* verification/tb.sv */
`timescale 1ns/10ps
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin error_cnt++; $display("[ERR] %s exp %0h got %0h", n, e, s); end end
module tb;
  import cbe_pkg::*;
  // ====================
  // Stimulus, expectations and verdict
  logic ref_clk = 1'h0, rst_b = 1'h0, br_valid = 1'h0, hit, pc_load, flush, busy, done, taken;
  logic flag_carry = 1'h0, flag_negative = 1'h0, flag_overflow = 1'h0, flag_halfcarry = 1'h0, flag_transfer = 1'h0;
  logic [6:0] br_offset = 7'h00;
  logic [15:0] pc_in = 16'h0000, pc_target;
  cbe_cond_t br_cond = cbe_cond_t'(4'h0);
  int error_cnt = 0, compares = 0;
  cbe_branch_eval uut (
    .ref_clk        (ref_clk),
    .rst_b          (rst_b),
    .br_valid       (br_valid),
    .br_cond        (br_cond),
    .br_offset      (br_offset),
    .pc_in          (pc_in),
    .flag_carry     (flag_carry),
    .flag_negative  (flag_negative),
    .flag_overflow  (flag_overflow),
    .flag_halfcarry (flag_halfcarry),
    .flag_transfer  (flag_transfer),
    .pc_load        (pc_load),
    .pc_target      (pc_target),
    .flush          (flush),
    .busy           (busy),
    .done           (done),
    .taken          (taken)
  );
  initial forever #5 ref_clk = ~ref_clk;
  // Valid stays up through busy, so every taken jump also meets a refused request
  task automatic branch(input logic [3:0] k, input logic [4:0] f, input logic [6:0] o, input logic [15:0] p);
    logic [4:0] fs;
    fs = {f[0], f[1], f[3] ^ f[2], f[3], f[4]};
    hit = k < 4'hB && fs[k < 4 ? 0 : (k - 2) >> 1] ^ (k inside {1, 2, 5, 6, 9});
    {br_valid, flag_carry, flag_negative, flag_overflow, flag_halfcarry, flag_transfer, br_offset, pc_in} =
      {1'h1, f, o, p};
    br_cond = cbe_cond_t'(k);
    @(posedge ref_clk) #1;
    `CHK("taken", hit, taken)
    `CHK("load flush busy done", {{3{hit}}, !hit}, {pc_load, flush, busy, done})
    if (hit) begin
      `CHK("target", p + {{9{o[6]}}, o} + 16'h0001, pc_target)
      @(posedge ref_clk) #1;
      `CHK("taken busy done", 3'h1, {taken, busy, done})
    end
  endtask
  task automatic tally_and_finish;
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge ref_clk);
    #1 `CHK("reset outputs", 21'h0, {pc_load, flush, busy, done, taken, pc_target})
    rst_b = 1'h1;
    for (int i = 0; i < 512; i++) begin
      branch(i[3:0], i[8:4], 7'(i * 37), 16'(i * 4099));
    end
    // Reset dropped inside a taken jump must leave no pulse and no address behind
    br_cond = CBE_JUMP_WHEN_CARRY_SET;
    flag_carry = 1'h1;
    @(posedge ref_clk) #1;
    `CHK("busy before reset", 1'h1, busy)
    {rst_b, br_valid} = 2'h0;
    #1 `CHK("mid reset outputs", 21'h0, {pc_load, flush, busy, done, taken, pc_target})
    repeat (2) @(posedge ref_clk);
    #1 rst_b = 1'h1;
    branch(4'h0, 5'h10, 7'h7F, 16'h0000);
    branch(4'hA, 5'h01, 7'h3F, 16'hFFF0);
    br_valid = 1'h0;
    tally_and_finish;
  end
  // Traffic needs about 720 cycles; allow about four times that
  initial begin
    #30000 error_cnt++;
    tally_and_finish;
  end
endmodule
